// >>> rtl/reset_and_interrupt_ack.sv
`timescale 1ns/100ps
`default_nettype none
module reset_and_interrupt_ack (
  input  wire logic                               CLK_SYS,
  input  wire logic                               NRST,
  input  wire logic                               PH1_FALL,
  input  wire logic                               PH1_RISE,
  input  wire logic                               PH3_EDGE,
  input  wire logic                               BOOT_MODE_SELECT,
  input  wire logic [rst_intr_pkg::NUM_INTR-1:0]  EXT_INTR_REQ_N,
  input  wire logic [rst_intr_pkg::NUM_INTR-1:0]  INTR_EDGE_MODE,
  input  wire logic [rst_intr_pkg::NUM_INTR-1:0]  INTR_CLEAR,
  input  wire logic                               ACK_DECODE_START,
  input  wire logic                               ACK_READ_START,
  input  wire logic                               BUS_WAIT,
  output logic                                    INTR_ACK_STROBE_N,
  output logic                                    MEM_BANK_STROBE_N,
  output logic                                    PERIPH_STROBE_N,
  output logic                                    STROBE_OE,
  output logic                                    RW_OE,
  output logic                                    DATA_OE,
  output logic                                    ADDR_OE,
  output logic                                    ASYNC_PINS_OE,
  output logic                                    VECTOR_FETCH,
  output logic [2:0]                              FETCH_WAIT_STATES,
  output logic                                    CPU_RUN,
  output logic [rst_intr_pkg::NUM_INTR-1:0]       INTR_PENDING
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencing
  rst_intr_pkg::seq_state_type seq_reg;
  rst_intr_pkg::seq_state_type seq_next;
  logic [1:0]                  fetch_cnt_reg;
  logic [2:0]                  wait_cnt_reg;
  logic [2:0]                  wait_load;
  logic                        boot_reg;
  rst_intr_pkg::drive_type     drv_reg;
  logic                        in_reset_state;
  logic                        in_fetch_state;
  logic                        in_wait_state;
  logic                        no_wait_boot;
  logic                        last_wait;
  logic                        fetch_done;
  logic                        wait_done;
  logic                        bus_cycle_next;
  logic                        fetch_next;
  logic                        run_next;

  // Wait states chosen by the boot strap caught at release
  assign wait_load = boot_reg ? rst_intr_pkg::BOOT_WAIT_ONCHIP
                              : rst_intr_pkg::BOOT_WAIT_PROC;

  // State decodes shared by the sequencer and the bus drivers
  assign in_reset_state = (seq_reg == rst_intr_pkg::SEQ_RESET);
  assign in_fetch_state = (seq_reg == rst_intr_pkg::SEQ_FETCH);
  assign in_wait_state  = (seq_reg == rst_intr_pkg::SEQ_WAIT);
  assign no_wait_boot   = (wait_load == rst_intr_pkg::BOOT_WAIT_ONCHIP);
  assign last_wait      = (wait_cnt_reg == 3'h1);

  // Boot ends after the second fetch, or after the last wait that follows it
  assign fetch_done = in_fetch_state && (fetch_cnt_reg == 2'h1) && no_wait_boot;
  assign wait_done  = in_wait_state && last_wait && (fetch_cnt_reg == 2'h0);

  // Release only counts on a phase-one fall; a missed one costs a cycle
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      rst_intr_pkg::SEQ_RESET: if (PH1_FALL) seq_next = rst_intr_pkg::SEQ_SYNC;
      rst_intr_pkg::SEQ_SYNC:  seq_next = rst_intr_pkg::SEQ_FETCH;
      rst_intr_pkg::SEQ_FETCH: seq_next = no_wait_boot ? rst_intr_pkg::SEQ_FETCH : rst_intr_pkg::SEQ_WAIT;
      rst_intr_pkg::SEQ_WAIT:  if (last_wait) seq_next = rst_intr_pkg::SEQ_FETCH;
      rst_intr_pkg::SEQ_RUN:   seq_next = rst_intr_pkg::SEQ_RUN;
      default:                 seq_next = rst_intr_pkg::SEQ_RESET;
    endcase
    // Either way of finishing the boot overrides the per-state choice
    if (fetch_done || wait_done)
      seq_next = rst_intr_pkg::SEQ_RUN;
  end

  // Look-ahead decodes so the registered outputs line up with the state
  assign bus_cycle_next = (seq_next == rst_intr_pkg::SEQ_FETCH) || (seq_next == rst_intr_pkg::SEQ_WAIT);
  assign fetch_next     = (seq_next == rst_intr_pkg::SEQ_FETCH);
  assign run_next       = (seq_next == rst_intr_pkg::SEQ_RUN);

  // Sequencer state; the reset is synchronous, so pin floating follows the next edge
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      seq_reg       <= rst_intr_pkg::SEQ_RESET;
      fetch_cnt_reg <= rst_intr_pkg::VECTOR_FETCHES;
      wait_cnt_reg  <= 3'h0;
      boot_reg      <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      if (in_reset_state)
        boot_reg <= BOOT_MODE_SELECT;
      if (in_fetch_state) begin
        fetch_cnt_reg <= fetch_cnt_reg - 2'h1;
        wait_cnt_reg  <= wait_load;
      end else if (in_wait_state) begin
        wait_cnt_reg <= wait_cnt_reg - 3'h1;
      end
    end
  end

  // Bus drivers: strobes and address on phase three, data and direction on phase one.
  // Strobes must stay driven high through reset, so their enables are never cleared;
  // there is no bus hold logic here that would ever want them released.
  always_ff @(posedge CLK_SYS) begin
    if (PH3_EDGE) begin
      drv_reg.mem_strobe_oe    <= 1'b1;
      drv_reg.periph_strobe_oe <= 1'b1;
    end
    if (!NRST) begin
      drv_reg.rw_oe         <= 1'b0;
      drv_reg.data_oe       <= 1'b0;
      drv_reg.addr_oe       <= 1'b0;
      drv_reg.async_pins_oe <= 1'b0;
    end else begin
      drv_reg.async_pins_oe <= 1'b1;
      if (PH3_EDGE)
        drv_reg.addr_oe <= !in_reset_state;
      if (PH1_RISE) begin
        drv_reg.data_oe <= !in_reset_state;
        drv_reg.rw_oe   <= !in_reset_state;
      end
    end
  end

  // Memory strobe low through the vector fetches and their waits, high once the core runs; peripheral strobe always high
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      MEM_BANK_STROBE_N <= 1'b1;
      PERIPH_STROBE_N   <= 1'b1;
      VECTOR_FETCH      <= 1'b0;
      FETCH_WAIT_STATES <= 3'h0;
      CPU_RUN           <= 1'b0;
    end else begin
      MEM_BANK_STROBE_N <= ~bus_cycle_next;
      PERIPH_STROBE_N   <= 1'b1;
      VECTOR_FETCH      <= fetch_next;
      FETCH_WAIT_STATES <= wait_load;
      CPU_RUN           <= run_next;
    end
  end

  // Enables leave straight from their flops
  assign STROBE_OE     = drv_reg.mem_strobe_oe;
  assign RW_OE         = drv_reg.rw_oe;
  assign DATA_OE       = drv_reg.data_oe;
  assign ADDR_OE       = drv_reg.addr_oe;
  assign ASYNC_PINS_OE = drv_reg.async_pins_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt inputs, one slice per line
  genvar gi;
  generate
    for (gi = 0; gi < rst_intr_pkg::NUM_INTR; gi++) begin : g_intr
      logic sync1_reg;
      logic sync2_reg;
      logic prev_reg;
      logic pend_reg;
      logic fall_det;
      assign fall_det = prev_reg & ~sync2_reg;

      // First stage feeds only the second; sampling on phase-one fall
      always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
          sync1_reg <= 1'b1;
          sync2_reg <= 1'b1;
          prev_reg  <= 1'b1;
          pend_reg  <= 1'b0;
        end else begin
          if (PH1_FALL) begin
            sync1_reg <= EXT_INTR_REQ_N[gi];
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
          end
          // Level lines keep no memory: a long request simply shows as a long pending
          // A new edge wins over a clear in the same cycle
          if (INTR_EDGE_MODE[gi])
            pend_reg <= (PH1_FALL & fall_det) | (pend_reg & ~INTR_CLEAR[gi]);
          else
            pend_reg <= ~sync2_reg;
        end
      end
      assign INTR_PENDING[gi] = pend_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge strobe
  rst_intr_pkg::ack_state_type ack_reg;
  rst_intr_pkg::ack_state_type ack_next;
  logic                        decode_taken;
  logic                        read_taken;

  // Starts only count on a phase-one rise; a read start under wait is not taken,
  // which is what stretches the strobe by every inserted wait state
  assign decode_taken = PH1_RISE && ACK_DECODE_START;
  assign read_taken   = PH1_RISE && ACK_READ_START && !BUS_WAIT;

  // Low from decode start to read start; wait states only hold the read start back
  always_comb begin
    ack_next = ack_reg;
    case (ack_reg)
      rst_intr_pkg::ACK_IDLE: if (decode_taken) ack_next = rst_intr_pkg::ACK_LOW;
      rst_intr_pkg::ACK_LOW:  if (read_taken)
                                ack_next = rst_intr_pkg::ACK_HOLD;
      rst_intr_pkg::ACK_HOLD: ack_next = rst_intr_pkg::ACK_IDLE;
      default:                ack_next = rst_intr_pkg::ACK_IDLE;
    endcase
  end

  // Strobe forced high throughout reset
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ack_reg           <= rst_intr_pkg::ACK_IDLE;
      INTR_ACK_STROBE_N <= 1'b1;
    end else begin
      ack_reg           <= ack_next;
      INTR_ACK_STROBE_N <= ~(ack_next == rst_intr_pkg::ACK_LOW);
    end
  end

endmodule // reset_and_interrupt_ack
`default_nettype wire

// >>> rtl/rst_intr_pkg.sv
// Functional notes
// - Reset input accepted anytime; a missed sample adds one cycle of delay.
// - Read/write direction output floats for the whole time reset is held; here it floats from the next clock edge.
// - Boot select low: reset vector fetched twice, seven wait states each.
// - Boot select high: reset vector fetched twice, no wait states.
// - Reset low at once floats flag, serial and timer pins, no clock needed; here they float on the next clock edge.
// - During reset memory and peripheral strobes are driven high on phase three.
// - During reset data bus released to high impedance, timed from phase one; here it is released on the next clock edge.
// - During reset address bus released to high impedance, timed from phase three; here it is released on the next clock edge.
// - During reset acknowledge strobe driven high, synchronous to phase one; here it goes high on the next clock edge.
// - Acknowledge strobe stays active for whole bus cycle, stretched by wait states.
// - Acknowledge asserts at decode start, deasserts at read phase start.
// - Stretched decode phase still gives only one cycle of acknowledge low; here it stays low until the read start is taken, through every wait state.
package rst_intr_pkg;

  localparam int NUM_INTR        = 4;
  localparam int RESET_MIN_CYC   = 10;
  localparam logic [2:0] BOOT_WAIT_PROC = 3'h7;
  localparam logic [2:0] BOOT_WAIT_ONCHIP = 3'h0;
  localparam logic [1:0] VECTOR_FETCHES = 2'h2;
  localparam logic [3:0] RST_CNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    SEQ_RESET = 3'b000,
    SEQ_SYNC  = 3'b001,
    SEQ_FETCH = 3'b010,
    SEQ_WAIT  = 3'b011,
    SEQ_RUN   = 3'b100
  } seq_state_type;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_LOW  = 2'b01,
    ACK_HOLD = 2'b10
  } ack_state_type;

  typedef struct packed {
    logic mem_strobe_oe;
    logic periph_strobe_oe;
    logic rw_oe;
    logic data_oe;
    logic addr_oe;
    logic async_pins_oe;
  } drive_type;

endpackage : rst_intr_pkg

// >>> tb/rst_intr_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rst_intr_monitor (
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic       PH1_FALL,
  input wire logic       PH1_RISE,
  input wire logic       PH3_EDGE,
  input wire logic       BOOT_MODE_SELECT,
  input wire logic [3:0] INTR_EDGE_MODE,
  input wire logic [3:0] INTR_CLEAR,
  input wire logic       ACK_DECODE_START,
  input wire logic       ACK_READ_START,
  input wire logic       BUS_WAIT,
  input wire logic       INTR_ACK_STROBE_N,
  input wire logic       MEM_BANK_STROBE_N,
  input wire logic       PERIPH_STROBE_N,
  input wire logic       STROBE_OE,
  input wire logic       RW_OE,
  input wire logic       DATA_OE,
  input wire logic       ADDR_OE,
  input wire logic       ASYNC_PINS_OE,
  input wire logic       VECTOR_FETCH,
  input wire logic [2:0] FETCH_WAIT_STATES,
  input wire logic [3:0] INTR_PENDING
);
  logic boot_reg;
  // Boot select as held during reset; the sequencer samples it in SEQ_RESET once NRST is high
  always_ff @(posedge CLK_SYS) if (!NRST) boot_reg <= BOOT_MODE_SELECT;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////
  // Reset behaviour must be watched while reset is low, so no disable here
  float_in_rst_a: assert property (disable iff (1'b0) !NRST |=> !(RW_OE | DATA_OE | ADDR_OE | ASYNC_PINS_OE))
    else $error("pin drivers active during reset");
  strobe_drive_a: assert property (disable iff (1'b0) PH3_EDGE |=> STROBE_OE)
    else $error("strobe drivers not enabled after phase three");
  strobe_rst_a: assert property (disable iff (1'b0) !NRST |=> MEM_BANK_STROBE_N && PERIPH_STROBE_N)
    else $error("strobes not high during reset");
  ack_rst_a: assert property (disable iff (1'b0) !NRST |=> INTR_ACK_STROBE_N && INTR_PENDING == 4'h0)
    else $error("acknowledge or pending active during reset");
  async_rel_a: assert property (disable iff (1'b0) $rose(NRST) |=> ASYNC_PINS_OE)
    else $error("async pins not driven after reset");
  ack_fall_a: assert property ($fell(INTR_ACK_STROBE_N) |-> $past(PH1_RISE && ACK_DECODE_START))
    else $error("acknowledge fell without decode start");
  ack_rise_a: assert property ($rose(INTR_ACK_STROBE_N) |-> $past(PH1_RISE && ACK_READ_START && !BUS_WAIT))
    else $error("acknowledge rose without read start");
  ack_wait_a: assert property (!INTR_ACK_STROBE_N && (BUS_WAIT || !PH1_RISE) |=> !INTR_ACK_STROBE_N)
    else $error("acknowledge ended during wait");
  boot_wait_a: assert property (VECTOR_FETCH |-> FETCH_WAIT_STATES == (boot_reg ? 3'h0 : 3'h7))
    else $error("wrong wait states on vector fetch");
  edge_hold_a: assert property (1'b1 |=> ($past(INTR_PENDING & INTR_EDGE_MODE & ~INTR_CLEAR) & ~INTR_PENDING) == 4'h0)
    else $error("edge pending dropped without clear");
  req_sample_a: assert property ((INTR_PENDING & ~$past(INTR_PENDING)) != 4'h0 |-> $past(PH1_FALL) || $past(PH1_FALL, 2))
    else $error("pending set away from phase one fall");
endmodule // rst_intr_monitor
bind reset_and_interrupt_ack rst_intr_monitor mon (.*);
`default_nettype wire

// >>> tb/rst_intr_partner.sv
`timescale 1ns/100ps
`default_nettype none
module rst_intr_partner (
  input  wire logic       clk,
  input  wire logic       rst_go,
  input  wire logic [3:0] req_go,
  input  wire logic       long_go,
  output logic            nrst,
  output logic            ph1_rise,
  output logic            ph3_edge,
  output logic            ph1_fall,
  output logic [3:0]      req_n
);
  logic [1:0] ph_reg = 2'h0;
  logic [5:0] rcnt_reg = 6'h0;
  logic [3:0] icnt_reg = 4'h0;
  initial nrst = 1'b0;
  initial req_n = 4'hf;
  // Phase edges repeat every four system clocks
  assign ph1_rise = ph_reg == 2'h0;
  assign ph3_edge = ph_reg == 2'h1;
  assign ph1_fall = ph_reg == 2'h2;
  // Reset spans ten phase periods and lets go just before a phase one fall
  always @(posedge clk) begin
    ph_reg <= ph_reg + 2'h1;
    if (rst_go) begin
      nrst <= 1'b0;
      rcnt_reg <= 6'h0;
    end else if (rcnt_reg < 6'(4 * rst_intr_pkg::RESET_MIN_CYC)) rcnt_reg <= rcnt_reg + 6'h1;
    else if (ph_reg == 2'h1) nrst <= 1'b1;
    // Short request stays under two periods so a level line is taken once
    if (req_go != 4'h0) begin
      req_n <= ~req_go;
      icnt_reg <= long_go ? 4'h8 : 4'h4;
    end else if (icnt_reg != 4'h0) icnt_reg <= icnt_reg - 4'h1;
    else req_n <= 4'hf;
  end
endmodule // rst_intr_partner
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic CLK_SYS = 1'b0, BOOT_MODE_SELECT = 1'b0, ACK_DECODE_START = 1'b0, ACK_READ_START = 1'b0, BUS_WAIT = 1'b0;
  logic rst_go = 1'b0, long_go = 1'b0, NRST, PH1_FALL, PH1_RISE, PH3_EDGE, INTR_ACK_STROBE_N, VECTOR_FETCH, CPU_RUN;
  logic [3:0] req_go = 4'h0, INTR_EDGE_MODE = 4'hf, INTR_CLEAR = 4'h0, EXT_INTR_REQ_N, INTR_PENDING, pend_last = 4'h0;
  logic [2:0] FETCH_WAIT_STATES;
  logic [31:0] r;
  logic [2:0] fq[$];
  logic [3:0] pq[$];
  logic [7:0] aq[$];
  int num_errors = 0, num_checks = 0, seed, low = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  rst_intr_partner pm (.clk(CLK_SYS), .rst_go(rst_go), .req_go(req_go), .long_go(long_go), .nrst(NRST),
    .ph1_rise(PH1_RISE), .ph3_edge(PH3_EDGE), .ph1_fall(PH1_FALL), .req_n(EXT_INTR_REQ_N));
  reset_and_interrupt_ack DUT (.CLK_SYS(CLK_SYS), .NRST(NRST), .PH1_FALL(PH1_FALL), .PH1_RISE(PH1_RISE),
    .PH3_EDGE(PH3_EDGE), .BOOT_MODE_SELECT(BOOT_MODE_SELECT), .EXT_INTR_REQ_N(EXT_INTR_REQ_N),
    .INTR_EDGE_MODE(INTR_EDGE_MODE), .INTR_CLEAR(INTR_CLEAR), .ACK_DECODE_START(ACK_DECODE_START),
    .ACK_READ_START(ACK_READ_START), .BUS_WAIT(BUS_WAIT), .INTR_ACK_STROBE_N(INTR_ACK_STROBE_N),
    .MEM_BANK_STROBE_N(), .PERIPH_STROBE_N(), .STROBE_OE(), .RW_OE(), .DATA_OE(), .ADDR_OE(), .ASYNC_PINS_OE(),
    .VECTOR_FETCH(VECTOR_FETCH), .FETCH_WAIT_STATES(FETCH_WAIT_STATES), .CPU_RUN(CPU_RUN), .INTR_PENDING(INTR_PENDING));
  ////////////////////////////////////////////////////////////////
  task automatic report(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_fetch(input logic [2:0] got, input logic [2:0] exp); report({5'h0, got}, {5'h0, exp}); endtask
  task automatic check_pend(input logic [3:0] got, input logic [3:0] exp); report({4'h0, got}, {4'h0, exp}); endtask
  task automatic check_ack(input logic [7:0] got, input logic [7:0] exp); report(got, exp); endtask
  // Stops one clock before a phase one rise, so inputs set now meet that rise
  task automatic at_rise;
    do @(posedge CLK_SYS); while (pm.ph_reg != 2'h3);
  endtask
  task automatic do_reset(input logic b);
    int n;
    @(posedge CLK_SYS);
    BOOT_MODE_SELECT <= b;
    repeat (2) fq.push_back(b ? 3'h0 : 3'h7);
    rst_go <= 1'b1;
    @(posedge CLK_SYS) rst_go <= 1'b0;
    n = 0;
    repeat (3) @(posedge CLK_SYS);
    while (CPU_RUN !== 1'b1 && n < 200) begin
      @(posedge CLK_SYS);
      n++;
    end
    check_fetch(3'(fq.size()), 3'h0);
  endtask
  // Decode requests repeated during the wait must be ignored
  task automatic ack_cycle(input int w);
    aq.push_back(8'(4 * (w + 1)));
    at_rise();
    ACK_DECODE_START <= 1'b1;
    at_rise();
    ACK_DECODE_START <= w != 0;
    ACK_READ_START <= 1'b1;
    BUS_WAIT <= w != 0;
    repeat (w) at_rise();
    if (w != 0) BUS_WAIT <= 1'b0;
    at_rise();
    ACK_DECODE_START <= 1'b0;
    ACK_READ_START <= 1'b0;
  endtask
  task automatic intr(input logic [1:0] i, input logic lng, input logic edg);
    logic [3:0] b;
    b = 4'h1 << i;
    pq.push_back(b);
    pq.push_back(4'h0);
    @(posedge CLK_SYS) INTR_EDGE_MODE <= edg ? 4'hf : 4'h0;
    @(posedge CLK_SYS) req_go <= b;
    // Level lines only get the short pulse, so they stay under two periods
    long_go <= lng & edg;
    @(posedge CLK_SYS) req_go <= 4'h0;
    repeat (24) @(posedge CLK_SYS);
    INTR_CLEAR <= b;
    @(posedge CLK_SYS) INTR_CLEAR <= 4'h0;
    repeat (16) @(posedge CLK_SYS);
  endtask
  // Outputs are settled at the falling edge; each result takes the oldest note
  always @(negedge CLK_SYS) if (NRST === 1'b1) begin
    if (VECTOR_FETCH) check_fetch(FETCH_WAIT_STATES, fq.size() ? fq.pop_front() : 3'hx);
    if (INTR_PENDING !== pend_last) check_pend(INTR_PENDING, pq.size() ? pq.pop_front() : 4'hx);
    pend_last = INTR_PENDING;
    if (!INTR_ACK_STROBE_N) low++;
    else if (low != 0) check_ack(8'(low), aq.size() ? aq.pop_front() : 8'hx);
    if (INTR_ACK_STROBE_N) low = 0;
  end
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
  initial begin
    seed = 22;
    do_reset(1'b0);
    do_reset(1'b1);
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      intr(r[1:0], r[2], r[3]);
      ack_cycle(int'(r[5:4]));
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
